// ---- core/thermal_power_guard.sv ----
/*
   Power-good, reset and thermal protection logic with an APB register slave.
   Assumes board power control drives power_good and cold_start_hold_n asynchronously,
   a digital die temperature code on core_clk, and a wired-low hot_throttle_n pin.
*/
`timescale 1ns/1ps
module thermal_power_guard
   import thermal_power_guard_pkg::*;
(
   input  wire logic                                 core_clk,
   input  wire logic                                 sys_rst,
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [thermal_power_guard_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                          pwdata,
   output logic      [31:0]                          prdata,
   output logic                                      pready,
   output logic                                      pslverr,
   input  wire logic                                 power_good,
   input  wire logic                                 cold_start_hold_n,
   input  wire logic                                 acpi_c3,
   input  wire logic [7:0]                           die_temp,
   input  wire logic                                 hot_throttle_n_in,
   output logic                                      hot_throttle_n_out,
   output logic                                      hot_throttle_n_oe,
   output logic                                      io_isolate,
   output logic                                      dram_pin_oe,
   output logic                                      dram_clk_enable,
   output logic                                      dram_reset_n,
   output logic      [5:0]                           core_voltage_code,
   output logic                                      core_low_power,
   output logic                                      dram_clock_run,
   output logic      [3:0]                           mem_clk_div,
   output logic                                      core_clock_grid_en,
   output logic                                      bridge_clock_grid_en,
   output logic                                      clocks_stopped,
   output logic                                      overtemp_shutdown_n,
   output logic                                      sw_thermal_alert,
   output logic      [7:0]                           alert_type,
   output logic                                      alert_bus_cycle,
   output logic                                      throttle_enter_cycle,
   output logic                                      throttle_exit_cycle
);
   import thermal_power_guard_pkg::*;

   // ==========================================================================
   // Declarations
   // ==========================================================================
   logic [31:0] ctrl_reg;
   logic [31:0] alert_reg;
   logic [31:0] limit_reg;
   logic [3:0]  memclk_reg;
   logic        memclk_run_reg;
   logic [31:0] rdata_reg;
   logic        pg_s1_reg, pg_s2_reg;
   logic        hold_s1_reg, hold_s2_reg;
   logic        hot_s1_reg, hot_s2_reg, hot_s3_reg;
   logic [2:0]  hot_cnt_reg;
   logic        hot_lvl_reg;
   logic        throttle_reg;
   logic [10:0] thr_cnt_reg;
   logic        trip_reg;
   logic        above_hi_reg;
   logic        alert_irq_reg, alert_bus_reg;
   logic        enter_cyc_reg, exit_cyc_reg;

   // ==========================================================================
   // Bus decode
   // ==========================================================================
   wire setup_rd   = psel && !penable && !pwrite;
   wire access_wr  = psel && penable && pwrite;
   wire hit_ctrl   = (paddr == CTRL_ADDR);
   wire hit_alert  = (paddr == ALERT_ADDR);
   wire hit_limit  = (paddr == LIMIT_ADDR);
   wire hit_memclk = (paddr == MEMCLK_ADDR);
   wire hit_status = (paddr == STATUS_ADDR);
   wire mapped     = hit_ctrl || hit_alert || hit_limit || hit_memclk || hit_status;
   wire memclk_wr  = access_wr && hit_memclk;

   // Every access finishes in its first access cycle; unmapped ones report an error.
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = rdata_reg;

   // ==========================================================================
   // Threshold fields
   // ==========================================================================
   wire       htc_en   = ctrl_reg[CTRL_HTC_EN];
   wire       via_bus  = ctrl_reg[CTRL_VIA_BUS];
   wire [7:0] hi_thr   = alert_reg[7:0];
   wire [7:0] lo_thr   = alert_reg[15:8];
   wire [7:0] thr_lim  = limit_reg[7:0];
   wire [7:0] thr_hyst = limit_reg[15:8];
   wire [7:0] trip_thr = limit_reg[23:16];

   // Comparisons are made every cycle on the current code.
   wire over_hi   = die_temp > hi_thr;
   wire under_lo  = die_temp < lo_thr;
   wire over_lim  = die_temp > thr_lim;
   wire over_trip = die_temp > trip_thr;
   // Hysteresis is added in nine bits so a large margin cannot wrap round.
   wire cool      = ({1'b0, die_temp} + {1'b0, thr_hyst}) < {1'b0, thr_lim};

   // ==========================================================================
   // Power and thermal qualifiers
   // ==========================================================================
   wire run_ok    = pg_s2_reg && hold_s2_reg;
   // The pin is masked while this end drives it, since the wire then reads its own low.
   wire hot_ign   = trip_reg || !run_ok || !htc_en || throttle_reg;
   wire hot_act   = !hot_lvl_reg;
   wire period_end = (thr_cnt_reg == 11'(THR_PERIOD_CYC - 1));
   wire enter_go  = !throttle_reg && run_ok && !acpi_c3 && htc_en && !trip_reg
                    && (over_lim || hot_act);
   // Except when run_ok drops, leaving is checked at a period boundary so the throttle lasts whole periods.
   wire exit_go   = throttle_reg && (!run_ok || (period_end && cool && !hot_act));
   wire hi_ev     = run_ok && over_hi && !above_hi_reg;
   wire lo_ev     = run_ok && above_hi_reg && under_lo;
   wire alert_go  = (hi_ev && ctrl_reg[CTRL_HI_EN]) || (lo_ev && ctrl_reg[CTRL_LO_EN]);

   // ==========================================================================
   // Output assignments
   // ==========================================================================
   assign io_isolate           = !pg_s2_reg;
   assign dram_pin_oe          = run_ok;
   assign dram_reset_n         = run_ok;
   assign dram_clk_enable      = run_ok && memclk_run_reg;
   assign dram_clock_run       = memclk_run_reg;
   assign mem_clk_div          = memclk_reg;
   assign core_voltage_code    = pg_s2_reg ? ctrl_reg[CTRL_VID_LSB +: 6] : STARTUP_VID;
   assign core_low_power       = !hold_s2_reg;
   assign clocks_stopped       = trip_reg;
   assign overtemp_shutdown_n  = !trip_reg;
   // Only the core grid is ramped; the bridge grid stops only on a trip.
   assign bridge_clock_grid_en = !trip_reg;
   assign core_clock_grid_en   = !trip_reg && !core_low_power
                                 && !(throttle_reg && thr_cnt_reg < 11'(THR_OFF_CYC));
   assign hot_throttle_n_out   = 1'b0;
   assign hot_throttle_n_oe    = throttle_reg;
   assign sw_thermal_alert     = alert_irq_reg;
   assign alert_bus_cycle      = alert_bus_reg;
   assign alert_type           = ctrl_reg[CTRL_TYPE_LSB +: 8];
   assign throttle_enter_cycle = enter_cyc_reg;
   assign throttle_exit_cycle  = exit_cyc_reg;

   // ==========================================================================
   // Registers written by software
   // ==========================================================================
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_reg   <= CTRL_RST;
         alert_reg  <= ALERT_RST;
         limit_reg  <= LIMIT_RST;
         memclk_reg <= MEMCLK_RST;
      end
      else if (access_wr)
      begin
         if (hit_ctrl)
            ctrl_reg <= pwdata;
         else if (hit_alert)
            alert_reg <= pwdata;
         else if (hit_limit)
            limit_reg <= pwdata;
         else if (hit_memclk)
            memclk_reg <= pwdata[3:0];
      end
   end

   // Read data is captured in the setup cycle so it comes from a flip-flop.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_reg <= 32'h0000_0000;
      else if (setup_rd)
      begin
         if (hit_ctrl)
            rdata_reg <= ctrl_reg;
         else if (hit_alert)
            rdata_reg <= alert_reg;
         else if (hit_limit)
            rdata_reg <= limit_reg;
         else if (hit_memclk)
            rdata_reg <= {28'h0000000, memclk_reg};
         else if (hit_status)
            rdata_reg <= {19'h00000, memclk_run_reg, hot_act, above_hi_reg, trip_reg,
                          throttle_reg, die_temp};
         else
            rdata_reg <= 32'h0000_0000;
      end
   end

   // Memory clocks start on a divisor write and stop again with each reset.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         memclk_run_reg <= 1'b0;
      else if (!hold_s2_reg)
         memclk_run_reg <= 1'b0;
      else if (memclk_wr)
         memclk_run_reg <= 1'b1;
   end

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pg_s1_reg   <= 1'b0;
         pg_s2_reg   <= 1'b0;
         hold_s1_reg <= 1'b0;
         hold_s2_reg <= 1'b0;
         hot_s1_reg  <= 1'b1;
         hot_s2_reg  <= 1'b1;
         hot_s3_reg  <= 1'b1;
      end
      else
      begin
         pg_s1_reg   <= power_good;
         pg_s2_reg   <= pg_s1_reg;
         hold_s1_reg <= cold_start_hold_n;
         hold_s2_reg <= hold_s1_reg;
         hot_s1_reg  <= hot_throttle_n_in;
         hot_s2_reg  <= hot_s1_reg;
         hot_s3_reg  <= hot_s2_reg;
      end
   end

   // A level is taken only after it has held for the full stability count.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hot_cnt_reg <= 3'h0;
         hot_lvl_reg <= 1'b1;
      end
      else
      begin
         // Counting restarts while the pin is ignored, so the stale low of our own
         // drive still in the synchronisers cannot be taken once throttling ends.
         if (hot_ign || hot_s2_reg != hot_s3_reg)
            hot_cnt_reg <= 3'h0;
         else if (hot_cnt_reg != 3'(HOT_STABLE_CYC))
            hot_cnt_reg <= hot_cnt_reg + 3'h1;
         if (hot_ign)
            hot_lvl_reg <= 1'b1;
         else if (hot_cnt_reg == 3'(HOT_STABLE_CYC))
            hot_lvl_reg <= hot_s3_reg;
      end
   end

   // ==========================================================================
   // Hardware throttle state and its period counter
   // ==========================================================================
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         throttle_reg  <= 1'b0;
         thr_cnt_reg   <= 11'h000;
         enter_cyc_reg <= 1'b0;
         exit_cyc_reg  <= 1'b0;
      end
      else
      begin
         enter_cyc_reg <= enter_go && ctrl_reg[CTRL_CYC_EN];
         exit_cyc_reg  <= exit_go && ctrl_reg[CTRL_CYC_EN];
         if (enter_go)
            throttle_reg <= 1'b1;
         else if (exit_go)
            throttle_reg <= 1'b0;
         // Each period is roughly 6 us; the first half has the grid ramped down.
         if (!throttle_reg || period_end)
            thr_cnt_reg <= 11'h000;
         else
            thr_cnt_reg <= thr_cnt_reg + 11'h001;
      end
   end

   // ==========================================================================
   // Software alerts
   // ==========================================================================
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         above_hi_reg  <= 1'b0;
         alert_irq_reg <= 1'b0;
         alert_bus_reg <= 1'b0;
      end
      else
      begin
         if (hi_ev)
            above_hi_reg <= 1'b1;
         else if (lo_ev)
            above_hi_reg <= 1'b0;
         alert_irq_reg <= alert_go && !via_bus;
         alert_bus_reg <= alert_go && via_bus;
      end
   end

   // ==========================================================================
   // Overtemperature latch
   // ==========================================================================
   // Cleared only by sys_rst or reset hold, so a trip still present at release returns at once.
   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
         trip_reg <= 1'b0;
      else if (!hold_s2_reg)
         trip_reg <= 1'b0;
      else if (pg_s2_reg && over_trip)
         trip_reg <= 1'b1;
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   a_pg_isolation: assert property (
      !pg_s2_reg |-> io_isolate && !dram_pin_oe && core_voltage_code == STARTUP_VID)
      else $error("Power planes not isolated while power good is low.");
   a_dram_park_low: assert property (
      !pg_s2_reg |-> !dram_clk_enable && !dram_reset_n)
      else $error("Memory clock enable or reset not low without power good.");
   a_reset_low_power: assert property (
      !hold_s2_reg |-> core_low_power && !dram_clk_enable && !dram_reset_n)
      else $error("Core not parked during reset hold.");
   a_memclk_start: assert property (
      $rose(memclk_run_reg) |-> $past(memclk_wr))
      else $error("Memory clock started without a divisor write.");
   a_throttle_entry: assert property (
      $rose(throttle_reg) |-> $past(run_ok) && !$past(acpi_c3))
      else $error("Throttle entered outside its allowed conditions.");
   a_grid_ramp: assert property (
      throttle_reg && thr_cnt_reg < 11'(THR_OFF_CYC) |-> !core_clock_grid_en)
      else $error("Core grid not ramped down in throttle off phase.");
   a_bridge_full: assert property (
      throttle_reg && !trip_reg |-> bridge_clock_grid_en)
      else $error("Bridge grid stopped during throttling.");
   a_pin_drive: assert property (
      $rose(throttle_reg) |-> hot_throttle_n_oe ##1 (hot_throttle_n_oe || !throttle_reg))
      else $error("Throttle pin not driven with throttle state.");
   a_hot_stable: assert property (
      $fell(hot_lvl_reg) |-> !$past(hot_s2_reg, 1) && !$past(hot_s2_reg, 2)
                             && !$past(hot_s2_reg, 3))
      else $error("Throttle pin low accepted before it was stable.");
   a_trip_latched: assert property (
      !overtemp_shutdown_n && hold_s2_reg |=> !overtemp_shutdown_n)
      else $error("Shutdown released without reset hold.");
   a_trip_stops: assert property (
      pg_s2_reg && hold_s2_reg && over_trip |=> !overtemp_shutdown_n && clocks_stopped)
      else $error("Trip point passed without shutdown.");
   a_alert_route: assert property (
      sw_thermal_alert |-> !alert_bus_cycle && !$past(via_bus))
      else $error("Alert sent on the wrong path.");
   a_throttle_cycle: assert property (
      $rose(throttle_reg) |-> throttle_enter_cycle == $past(ctrl_reg[CTRL_CYC_EN]))
      else $error("Throttle entry bus cycle wrong.");

endmodule : thermal_power_guard

// ---- core/thermal_power_guard_pkg.sv ----
/*
   Constants for the thermal and power guard: register map, field positions, reset values
   and timing counts. Assumes a 200 MHz core clock and a 32-bit APB register bus.
*/
package thermal_power_guard_pkg;

   // ==========================================================================
   // Clock and timing
   // ==========================================================================
   localparam int CLK_PERIOD_NS      = 5;
   localparam int HOT_STABLE_NS      = 10;
   // The pin must be stable strictly longer than the figure, hence one cycle more.
   localparam int HOT_STABLE_CYC     = HOT_STABLE_NS / CLK_PERIOD_NS + 1;
   localparam int THR_PERIOD_NS      = 6000;
   localparam int THR_PERIOD_CYC     = THR_PERIOD_NS / CLK_PERIOD_NS;
   localparam int THR_OFF_CYC        = THR_PERIOD_CYC / 2;

   // ==========================================================================
   // Register map, byte addresses
   // ==========================================================================
   localparam int ADDR_W             = 12;
   localparam logic [11:0] CTRL_ADDR   = 12'h000;
   localparam logic [11:0] ALERT_ADDR  = 12'h004;
   localparam logic [11:0] LIMIT_ADDR  = 12'h008;
   localparam logic [11:0] MEMCLK_ADDR = 12'h00C;
   localparam logic [11:0] STATUS_ADDR = 12'h010;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int CTRL_HTC_EN        = 0;
   localparam int CTRL_HI_EN         = 1;
   localparam int CTRL_LO_EN         = 2;
   localparam int CTRL_VIA_BUS       = 3;
   localparam int CTRL_CYC_EN        = 4;
   localparam int CTRL_TYPE_LSB      = 8;
   localparam int CTRL_VID_LSB       = 16;
   localparam int ST_THROTTLE        = 8;
   localparam int ST_TRIP            = 9;
   localparam int ST_ABOVE_HI        = 10;
   localparam int ST_HOT_IN          = 11;
   localparam int ST_MEMCLK          = 12;

   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] ALERT_RST  = 32'h0000_4050;
   localparam logic [31:0] LIMIT_RST  = 32'h00F0_0560;
   localparam logic [3:0]  MEMCLK_RST = 4'h0;
   localparam logic [5:0]  STARTUP_VID = 6'h00;

endpackage : thermal_power_guard_pkg

// ---- dv/board_power_model.sv ----
/* Board power and reset control model facing the guard.
   Assumes the bench requests power, hold and pin levels on core_clk. */
`timescale 1ns/1ps
module board_power_model
(
   input  wire logic core_clk,
   input  wire logic pg_req,
   input  wire logic hold_req_n,
   input  wire logic pin_req,
   input  wire logic overtemp_shutdown_n,
   output logic      power_good,
   output logic      cold_start_hold_n,
   output logic      pin_drive
);
   logic tripped = 1'h0;
   // ==========
   // Shutdown response
   // A trip counts only with power good and hold released; it then pulls power.
   always_ff @(posedge core_clk)
   begin
      if (!hold_req_n)
         tripped <= 1'h0;
      else if (!overtemp_shutdown_n && power_good && cold_start_hold_n)
         tripped <= 1'h1;
   end
   assign power_good = pg_req && !tripped;
   assign cold_start_hold_n = hold_req_n;
   // The bench holds a pin request past the stability count to get any effect.
   assign pin_drive = pin_req;
endmodule : board_power_model

// ---- dv/thermal_power_guard_tb_top.sv ----
/* Self-checking bench for the thermal and power guard.
   Assumes the board model is compiled before it. */
`timescale 1ns/1ps
module thermal_power_guard_tb_top;
   import thermal_power_guard_pkg::*;
   logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, power_good, acpi_c3;
   logic cold_start_hold_n, hot_throttle_n_in, hot_throttle_n_out, hot_throttle_n_oe;
   logic io_isolate, dram_pin_oe, dram_clk_enable, dram_reset_n, core_low_power;
   logic dram_clock_run, core_clock_grid_en, bridge_clock_grid_en, clocks_stopped;
   logic overtemp_shutdown_n, sw_thermal_alert, alert_bus_cycle, throttle_enter_cycle;
   logic throttle_exit_cycle, pg_req, hold_req_n, pin_req, pin_drive, er;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  die_temp, alert_type;
   logic [5:0]  core_voltage_code;
   logic [3:0]  mem_clk_div;
   int fail_count = 0, checks = 0, cyc = 0, n_al = 0, n_bus = 0, n_in = 0, n_out = 0;
   int base, off, boff;
   thermal_power_guard DUT
   (
      .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .power_good, .cold_start_hold_n, .acpi_c3, .die_temp, .hot_throttle_n_in,
      .hot_throttle_n_out, .hot_throttle_n_oe, .io_isolate, .dram_pin_oe, .dram_clk_enable,
      .dram_reset_n, .core_voltage_code, .core_low_power, .dram_clock_run, .mem_clk_div,
      .core_clock_grid_en, .bridge_clock_grid_en, .clocks_stopped, .overtemp_shutdown_n,
      .sw_thermal_alert, .alert_type, .alert_bus_cycle, .throttle_enter_cycle,
      .throttle_exit_cycle
   );
   board_power_model board
   (
      .core_clk, .pg_req, .hold_req_n, .pin_req, .overtemp_shutdown_n, .power_good,
      .cold_start_hold_n, .pin_drive
   );
   // Open-drain pin with a pull-up, low while either side pulls it.
   assign hot_throttle_n_in = !((hot_throttle_n_oe && !hot_throttle_n_out) || pin_drive);
   // Clock generator.
   initial
   begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Pulse tallies and the hang guard.
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      n_al <= n_al + (sw_thermal_alert === 1'h1);
      n_bus <= n_bus + (alert_bus_cycle === 1'h1);
      n_in <= n_in + (throttle_enter_cycle === 1'h1);
      n_out <= n_out + (throttle_exit_cycle === 1'h1);
      if (cyc == 20000)
      begin
         fail_count++;
         finish_test;
      end
   end
   // ==========
   // Shared tasks
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wt(ref logic s, input logic v, input int n);
      for (int k = 0; k < n && s !== v; k++)
         @(posedge core_clk);
   endtask : wt
   // Holds the request until pready is seen high, then releases it.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1)
         @(posedge core_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task finish_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // ==========
   // Scenarios
   task t_power;
      repeat (4) @(posedge core_clk);
      chk("iso", 1'h1, io_isolate);
      chk("pin_oe", 1'h0, dram_pin_oe);
      chk("rst_n", 1'h0, dram_reset_n);
      chk("vid", STARTUP_VID, core_voltage_code);
      pg_req <= 1'h1;
      repeat (4) @(posedge core_clk);
      chk("iso", 1'h0, io_isolate);
      chk("cke", 1'h0, dram_clk_enable);
      chk("lowp", 1'h1, core_low_power);
      hold_req_n <= 1'h1;
      apb(0, LIMIT_ADDR, 0);
      chk("limit", LIMIT_RST, rd);
      apb(0, 12'h0FC, 0);
      chk("slverr", 1'h1, er);
      chk("memrun", 1'h0, dram_clock_run);
      apb(1, MEMCLK_ADDR, 32'h3);
      repeat (2) @(posedge core_clk);
      chk("memrun", 1'h1, dram_clock_run);
      $display("power test done");
   endtask : t_power
   task t_alert;
      apb(1, CTRL_ADDR, 32'h0000_A506);
      base = n_al;
      die_temp <= 8'h51;
      repeat (4) @(posedge core_clk);
      chk("alerts", base + 1, n_al);
      chk("type", 8'hA5, alert_type);
      die_temp <= 8'h3F;
      repeat (4) @(posedge core_clk);
      chk("alerts", base + 2, n_al);
      apb(1, CTRL_ADDR, 32'h0000_A50E);
      base = n_bus;
      die_temp <= 8'h51;
      repeat (4) @(posedge core_clk);
      chk("buscyc", base + 1, n_bus);
      die_temp <= 8'h30;
      $display("alert test done");
   endtask : t_alert
   task t_throttle;
      apb(1, CTRL_ADDR, 32'h0015_0011);
      acpi_c3 <= 1'h1;
      die_temp <= 8'h61;
      repeat (10) @(posedge core_clk);
      chk("thr_c3", 1'h0, hot_throttle_n_oe);
      chk("vid", 6'h15, core_voltage_code);
      base = n_in;
      acpi_c3 <= 1'h0;
      wt(hot_throttle_n_oe, 1'h1, 10);
      chk("thr", 1'h1, hot_throttle_n_oe);
      chk("pin_out", 1'h0, hot_throttle_n_out);
      off = 0;
      boff = 0;
      // Count the ramped-down cycles of the core and bridge grids over one period.
      repeat (THR_PERIOD_CYC)
      begin
         @(posedge core_clk);
         off += !core_clock_grid_en;
         boff += !bridge_clock_grid_en;
      end
      chk("enter", base + 1, n_in);
      chk("grid_off", THR_OFF_CYC, off);
      chk("bridge_off", 0, boff);
      base = n_out;
      die_temp <= 8'h5A;
      wt(hot_throttle_n_oe, 1'h0, THR_PERIOD_CYC + 20);
      // Let the pulse tally take in the exit pulse before it is judged.
      repeat (2) @(posedge core_clk);
      chk("thr", 1'h0, hot_throttle_n_oe);
      chk("exit", base + 1, n_out);
      $display("throttle test done");
   endtask : t_throttle
   task t_pin;
      pin_req <= 1'h1;
      @(posedge core_clk) pin_req <= 1'h0;
      repeat (12) @(posedge core_clk);
      chk("glitch", 1'h0, hot_throttle_n_oe);
      pin_req <= 1'h1;
      wt(hot_throttle_n_oe, 1'h1, 20);
      chk("thr_pin", 1'h1, hot_throttle_n_oe);
      repeat (2 * THR_PERIOD_CYC) @(posedge core_clk);
      chk("thr_pin", 1'h1, hot_throttle_n_oe);
      pin_req <= 1'h0;
      wt(hot_throttle_n_oe, 1'h0, THR_PERIOD_CYC + 20);
      apb(1, CTRL_ADDR, 0);
      pin_req <= 1'h1;
      repeat (20) @(posedge core_clk);
      chk("thr_off", 1'h0, hot_throttle_n_oe);
      pin_req <= 1'h0;
      $display("pin test done");
   endtask : t_pin
   task t_trip;
      die_temp <= 8'hF1;
      wt(overtemp_shutdown_n, 1'h0, 6);
      chk("stopped", 1'h1, clocks_stopped);
      repeat (6) @(posedge core_clk);
      chk("iso", 1'h1, io_isolate);
      chk("shut_n", 1'h0, overtemp_shutdown_n);
      hold_req_n <= 1'h0;
      wt(overtemp_shutdown_n, 1'h1, 6);
      chk("shut_n", 1'h1, overtemp_shutdown_n);
      hold_req_n <= 1'h1;
      wt(overtemp_shutdown_n, 1'h0, 10);
      chk("shut_n", 1'h0, overtemp_shutdown_n);
      $display("trip test done");
   endtask : t_trip
   // Main sequence, with every input given a value at time zero.
   initial
   begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'h1, 47'h0};
      {acpi_c3, pg_req, hold_req_n, pin_req} = 4'h0;
      die_temp = 8'h30;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'h0;
      t_power;
      t_alert;
      t_throttle;
      t_pin;
      t_trip;
      finish_test;
   end
endmodule : thermal_power_guard_tb_top
